/* pkg/ntf_map.vh */
// Register map, field positions and encodings of the store fence unit
`ifndef NTF_MAP_VH
`define NTF_MAP_VH

// Register byte offsets on the register bus
`define NTF_CTRL_OFS 8'h00
`define NTF_STATUS_OFS 8'h04
`define NTF_FADDR_OFS 8'h08
`define NTF_NTCNT_OFS 8'h0C
`define NTF_FENCECNT_OFS 8'h10

// Control register fields and reset value
`define NTF_CTRL_PF_EN 0
`define NTF_CTRL_MERGE_EN 1
`define NTF_CTRL_FLUSH 2
`define NTF_CTRL_RESET 2'h3

// Status register fields
`define NTF_STAT_WC_EMPTY 0
`define NTF_STAT_FENCE 1
`define NTF_STAT_FAULT 2

// Bus responses
`define NTF_RESP_OKAY 2'h0
`define NTF_RESP_SLVERR 2'h2

// Request operation codes from the core
`define NTF_OP_STORE 3'h0
`define NTF_OP_MASKED 3'h1
`define NTF_OP_NT_INT 3'h2
`define NTF_OP_NT_PF 3'h3
`define NTF_OP_FENCE 3'h4
`define NTF_OP_PREFETCH 3'h5

// Memory type codes
`define NTF_MT_UC 3'h0
`define NTF_MT_WP 3'h1
`define NTF_MT_WT 3'h2
`define NTF_MT_WC 3'h3
`define NTF_MT_WB 3'h4

// Prefetch block is 32 bytes, packed-float stores need 16-byte alignment
`define NTF_PF_LSB 5
`define NTF_NTPF_ALIGN 4
`define NTF_HINT_NT 2'h0

`endif

/* verification/ntf_chk_monitor.sv */
// Port checker for the store fence unit
`timescale 1ns/100ps
module ntf_chk (
    input wire sys_clk_in,
    input wire rstn_in,
    input wire req_valid_in,
    input wire req_ready_out,
    input wire [2:0] req_op_in,
    input wire [31:0] req_addr_in,
    input wire [31:0] ds_base_in,
    input wire [31:0] destination_index_register_in,
    input wire [63:0] req_mask_in,
    input wire [2:0] req_memtype_in,
    input wire req_line_hit_in,
    input wire cwr_valid_out,
    input wire fill_valid_out,
    input wire fault_out,
    input wire bus_valid_out,
    input wire [31:0] bus_addr_out,
    input wire [7:0] bus_be_out,
    input wire [2:0] bus_memtype_out,
    input wire bus_weak_out
);
    default clocking @(posedge sys_clk_in);
    endclocking
    default disable iff (!rstn_in);
    // Taken request, implicit address and top bit of each mask byte
    wire tk = req_valid_in && req_ready_out;
    wire [31:0] ad = ds_base_in + destination_index_register_in;
    wire [7:0] ln;
    for (genvar k = 0; k < 8; k++) assign ln[k] = req_mask_in[8*k+7];
    property p_mask;
        tk && req_op_in == 3'h1 && req_memtype_in == 3'h0 |-> ##2
            bus_valid_out && bus_be_out == $past(ln, 2) && !bus_weak_out
            && bus_addr_out == $past(ad, 2) && bus_memtype_out == 3'h0;
    endproperty
    a_mask: assert property (p_mask)
        else $error("mask beat");
    property p_fault;
        tk && req_op_in == 3'h3 && req_addr_in[3:0] != 4'h0 |=>
            fault_out && !cwr_valid_out && !fill_valid_out;
    endproperty
    a_fault: assert property (p_fault)
        else $error("no fault");
    property p_pf; tk && req_op_in == 3'h5 |=> !fault_out; endproperty
    a_pf: assert property (p_pf)
        else $error("prefetch faulted");
    property p_nofill;
        tk && req_op_in != 3'h0 && req_op_in < 3'h4 |=> !fill_valid_out;
    endproperty
    a_nofill: assert property (p_nofill)
        else $error("nt fill");
    property p_hit;
        tk && req_op_in == 3'h2 && req_line_hit_in && req_memtype_in == 3'h4
            |=> cwr_valid_out;
    endproperty
    a_hit: assert property (p_hit)
        else $error("no hit write");
    property p_weak; bus_valid_out && bus_weak_out |-> bus_memtype_out == 3'h3;
    endproperty
    a_weak: assert property (p_weak)
        else $error("weak type");
    property p_fence;
        tk && req_op_in == 3'h4 |=> !req_ready_out until !bus_valid_out;
    endproperty
    a_fence: assert property (p_fence)
        else $error("fence passed");
    property p_fwait;
        tk && req_op_in == 3'h4 |=> !req_ready_out ##[1:60] req_ready_out;
    endproperty
    a_fwait: assert property (p_fwait)
        else $error("fence hung");
endmodule
bind ntf_store_unit ntf_chk ntf_chk_i (.*);

/* verification/ntf_core_model.sv */
// Core and memory stand-in facing the store unit
`timescale 1ns/100ps
module ntf_core_model (
    input wire sys_clk_in,
    input wire req_ready_out,
    output logic req_valid_in,
    output logic [2:0] req_op_in,
    output logic [31:0] req_addr_in,
    output wire [31:0] destination_index_register_in,
    output logic [63:0] req_data_in,
    output logic [63:0] req_mask_in,
    output logic [2:0] req_memtype_in,
    output logic req_line_hit_in,
    output logic bus_ready_in
);
    logic [1:0] cyc_q = 2'h0;
    // Index register feeds masked stores
    assign destination_index_register_in = req_addr_in;
    initial begin
        {req_valid_in, req_op_in, req_addr_in, req_data_in} = '0;
        {req_mask_in, req_memtype_in, req_line_hit_in} = '0;
    end
    // Bus takes one beat in four: back pressure
    always @(posedge sys_clk_in) begin
        cyc_q <= cyc_q + 2'h1;
        bus_ready_in <= cyc_q == 2'h0;
    end
    // Request stands until taken
    task issue(input [2:0] op, input [31:0] a, input [63:0] d,
            input [63:0] m, input [2:0] mt, input h);
        @(posedge sys_clk_in);
        {req_valid_in, req_op_in, req_addr_in} <= {1'h1, op, a};
        {req_data_in, req_mask_in} <= {d, m};
        {req_memtype_in, req_line_hit_in} <= {mt, h};
        do @(posedge sys_clk_in); while (req_ready_out !== 1'h1);
        req_valid_in <= 1'h0;
    endtask
endmodule

/* verification/tb_top.sv */
// Self-checking bench for the store fence unit
`timescale 1ns/100ps
`include "ntf_map.vh"
module tb_top;
    logic sys_clk_in = 1'h0;
    logic rstn_in = 1'h0;
    logic [31:0] ds_base_in = 32'h0000_4000;
    logic [1:0] req_hint_in = 2'h2;
    wire req_valid_in, req_ready_out, req_line_hit_in, bus_ready_in;
    wire [2:0] req_op_in, req_memtype_in, bus_memtype_out;
    wire [31:0] req_addr_in, destination_index_register_in, fault_addr_out;
    wire [31:0] cwr_addr_out, fill_addr_out, pf_addr_out, bus_addr_out;
    wire [63:0] req_data_in, req_mask_in, cwr_data_out, bus_data_out;
    wire cwr_valid_out, fill_valid_out, pf_valid_out, pf_nt_out, fault_out;
    wire bus_valid_out, bus_weak_out, s_axi_awready_out, s_axi_wready_out;
    wire s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
    wire [7:0] cwr_be_out, bus_be_out;
    wire [1:0] pf_level_out, s_axi_bresp_out, s_axi_rresp_out;
    wire [31:0] s_axi_rdata_out;
    logic [7:0] s_axi_awaddr_in = 8'h0, s_axi_araddr_in = 8'h0;
    logic [31:0] s_axi_wdata_in = 32'h0;
    logic [3:0] s_axi_wstrb_in = 4'hF;
    logic s_axi_awvalid_in = 1'h0, s_axi_wvalid_in = 1'h0;
    logic s_axi_bready_in = 1'h0, s_axi_arvalid_in = 1'h0;
    logic s_axi_rready_in = 1'h0;
    logic [3:0] wm;
    integer fails = 0, samples_checked = 0, seed = 32'h2A03;
    integer nw = 0, nt = 3, w, base;
    always #4 sys_clk_in = ~sys_clk_in;
    ntf_store_unit ntf_store_unit_i (.*);
    ntf_core_model ntf_core_model_i (.*);
    // Count weak beats the bus accepted
    always @(posedge sys_clk_in)
        nw <= nw + (bus_valid_out && bus_ready_in && bus_weak_out);
    function integer beats(input [3:0] m);
        beats = m[0] + m[1] + m[2] + m[3];
    endfunction
    task chk(input string n, input [31:0] s, input [31:0] e);
        samples_checked = samples_checked + 1;
        if (s !== e) begin
            fails = fails + 1;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    // One register access
    task ax(input w, input [7:0] ad, input [31:0] d, input [1:0] r);
        @(posedge sys_clk_in);
        {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} <= {ad, ad, d};
        {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= {3{w}};
        {s_axi_arvalid_in, s_axi_rready_in} <= {2{!w}};
        do begin
            @(posedge sys_clk_in);
            if (s_axi_awready_out) s_axi_awvalid_in <= 1'h0;
            if (s_axi_wready_out) s_axi_wvalid_in <= 1'h0;
            if (s_axi_arready_out) s_axi_arvalid_in <= 1'h0;
        end while ((w ? s_axi_bvalid_out : s_axi_rvalid_out) !== 1'h1);
        {s_axi_bready_in, s_axi_rready_in} <= 2'h0;
        if (!w) chk("rdata", s_axi_rdata_out, d);
        chk("resp", w ? s_axi_bresp_out : s_axi_rresp_out, r);
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Watchdog far past the run
    initial begin
        #80000;
        fails = fails + 1;
        tally_and_finish;
    end
    initial begin
        repeat (4) @(posedge sys_clk_in);
        rstn_in <= 1'h1;
        ax(0, `NTF_CTRL_OFS, `NTF_CTRL_RESET, `NTF_RESP_OKAY);
        ax(0, 8'h20, 32'h0, `NTF_RESP_SLVERR);
        // Masked uncached then misaligned store
        ntf_core_model_i.issue(3'h1, 32'h120, 64'h0123_4567_89AB_CDEF,
            64'h8000_80FF_0080_0080, 3'h0, 1'h0);
        ntf_core_model_i.issue(3'h3, 32'h208, 64'h0, 64'h0, 3'h4, 1'h0);
        ax(0, `NTF_FADDR_OFS, 32'h208, `NTF_RESP_OKAY);
        ax(1, `NTF_STATUS_OFS, 32'h0, `NTF_RESP_OKAY);
        ax(0, `NTF_STATUS_OFS, 32'h5, `NTF_RESP_OKAY);
        $display("test 1 done");
        // Words of a line merge; fence drains
        for (int r = 0; r < 6; r++) begin
            base = nw;
            wm = 4'h0;
            for (int k = 0; k < 3; k++) begin
                w = {$random(seed)} % 4;
                wm[w] = 1'h1;
                ntf_core_model_i.issue(3'h2, 32'h800 + 32 * r + 8 * w,
                    $random(seed), 64'h0, 3'h2 + r % 3, 1'h0);
            end
            ntf_core_model_i.issue(3'h4, 0, 0, 0, 0, 0);
            do @(posedge sys_clk_in); while (req_ready_out !== 1'h1);
            chk("weak beats", nw - base, beats(wm));
        end
        ntf_core_model_i.issue(3'h2, 32'h900, 64'h5, 64'h0, 3'h4, 1'h1);
        $display("test 2 done");
        // Random prefetches leave no trace
        for (int k = 0; k < 8; k++)
            ntf_core_model_i.issue(3'h5, $random(seed), 0, 0, k % 5, 0);
        ax(0, `NTF_NTCNT_OFS, 32'd21, `NTF_RESP_OKAY);
        ax(0, `NTF_FENCECNT_OFS, 32'h6, `NTF_RESP_OKAY);
        ax(0, `NTF_STATUS_OFS, 32'h5, `NTF_RESP_OKAY);
        $display("test 3 done");
        tally_and_finish;
    end
endmodule

/* verilog/ntf_store_unit.v */
// Non-temporal store, store fence and prefetch control unit
`timescale 1ns/100ps
`include "ntf_map.vh"
module ntf_store_unit #(
    parameter AW = 32,
    parameter IW = 2
) (
    input wire sys_clk_in,
    input wire rstn_in,
    // Request port from the execution core
    input wire req_valid_in,
    output wire req_ready_out,
    input wire [2:0] req_op_in,
    input wire [AW-1:0] req_addr_in,
    input wire [AW-1:0] ds_base_in,
    input wire [AW-1:0] destination_index_register_in,
    input wire [63:0] req_data_in,
    input wire [63:0] req_mask_in,
    input wire [2:0] req_memtype_in,
    input wire req_line_hit_in,
    input wire [1:0] req_hint_in,
    // Cache update and fill requests
    output wire cwr_valid_out,
    output wire [AW-1:0] cwr_addr_out,
    output wire [63:0] cwr_data_out,
    output wire [7:0] cwr_be_out,
    output wire fill_valid_out,
    output wire [AW-1:0] fill_addr_out,
    // Prefetch request
    output wire pf_valid_out,
    output wire [AW-1:0] pf_addr_out,
    output wire [1:0] pf_level_out,
    output wire pf_nt_out,
    // Memory bus writes
    output wire bus_valid_out,
    input wire bus_ready_in,
    output wire [AW-1:0] bus_addr_out,
    output wire [63:0] bus_data_out,
    output wire [7:0] bus_be_out,
    output wire [2:0] bus_memtype_out,
    output wire bus_weak_out,
    // Exception to the core
    output wire fault_out,
    output wire [AW-1:0] fault_addr_out,
    // AXI4-Lite register slave
    input wire [7:0] s_axi_awaddr_in,
    input wire s_axi_awvalid_in,
    output wire s_axi_awready_out,
    input wire [31:0] s_axi_wdata_in,
    input wire [3:0] s_axi_wstrb_in,
    input wire s_axi_wvalid_in,
    output wire s_axi_wready_out,
    output wire [1:0] s_axi_bresp_out,
    output wire s_axi_bvalid_out,
    input wire s_axi_bready_in,
    input wire [7:0] s_axi_araddr_in,
    input wire s_axi_arvalid_in,
    output wire s_axi_arready_out,
    output wire [31:0] s_axi_rdata_out,
    output wire [1:0] s_axi_rresp_out,
    output wire s_axi_rvalid_out,
    input wire s_axi_rready_in
);
    localparam S_IDLE = 2'h0;
    localparam S_BUS = 2'h1;
    localparam S_WC = 2'h2;
    localparam S_FENCE = 2'h3;

    // Top bit of each mask byte selects the matching data byte
    function [7:0] mask_msbs;
        input [63:0] m;
        integer k;
        begin
            mask_msbs = 8'h00;
            for (k = 0; k < 8; k = k + 1) begin
                mask_msbs[k] = m[k*8+7];
            end
        end
    endfunction

    // Register index decode: 0..4 mapped, 7 unmapped
    function [2:0] reg_sel;
        input [7:0] a;
        begin
            case (a)
                `NTF_CTRL_OFS: reg_sel = 3'h0;
                `NTF_STATUS_OFS: reg_sel = 3'h1;
                `NTF_FADDR_OFS: reg_sel = 3'h2;
                `NTF_NTCNT_OFS: reg_sel = 3'h3;
                `NTF_FENCECNT_OFS: reg_sel = 3'h4;
                default: reg_sel = 3'h7;
            endcase
        end
    endfunction

    reg [1:0] state_q;
    reg ready_q;
    reg [AW-1:0] h_addr_q;
    reg [63:0] h_data_q;
    reg [7:0] h_be_q;
    reg [2:0] h_mt_q;
    reg cwr_valid_q;
    reg [AW-1:0] cwr_addr_q;
    reg [63:0] cwr_data_q;
    reg [7:0] cwr_be_q;
    reg fill_valid_q;
    reg [AW-1:0] fill_addr_q;
    reg pf_valid_q;
    reg [AW-1:0] pf_addr_q;
    reg [1:0] pf_level_q;
    reg pf_nt_q;
    reg bus_valid_q;
    reg [AW-1:0] bus_addr_q;
    reg [63:0] bus_data_q;
    reg [7:0] bus_be_q;
    reg [2:0] bus_mt_q;
    reg bus_weak_q;
    reg fault_q;
    reg fault_seen_q;
    reg [AW-1:0] fault_addr_q;
    reg [15:0] nt_cnt_q;
    reg [15:0] fence_cnt_q;
    reg [1:0] ctrl_q;
    reg flush_req_q;
    reg awready_q;
    reg wready_q;
    reg aw_have_q;
    reg w_have_q;
    reg [7:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    reg bvalid_q;
    reg [1:0] bresp_q;
    reg arready_q;
    reg rvalid_q;
    reg [31:0] rdata_q;
    reg [1:0] rresp_q;

    wire take;
    wire is_masked;
    wire is_nt;
    wire uncached;
    wire [AW-1:0] eff_addr;
    wire [7:0] eff_be;
    wire wc_ready;
    wire wc_empty;
    wire wc_flush;
    wire drain_valid;
    wire [AW-1:0] drain_addr;
    wire [63:0] drain_data;
    wire [7:0] drain_be;
    wire drain_take;
    wire bus_free;
    wire reg_wr;

    assign take = req_valid_in && ready_q;
    assign is_masked = req_op_in == `NTF_OP_MASKED;
    assign is_nt = is_masked || req_op_in == `NTF_OP_NT_INT ||
        req_op_in == `NTF_OP_NT_PF;
    assign uncached = req_memtype_in == `NTF_MT_UC ||
        req_memtype_in == `NTF_MT_WP;
    // Masked store ignores the explicit address operand
    assign eff_addr = is_masked ?
        ds_base_in + destination_index_register_in : req_addr_in;
    assign eff_be = is_masked ? mask_msbs(req_mask_in) : 8'hFF;
    // Drain on line change, fence, flush or merge off
    assign wc_flush = (state_q == S_WC && !wc_ready) ||
        state_q == S_FENCE || flush_req_q ||
        !ctrl_q[`NTF_CTRL_MERGE_EN];
    assign bus_free = !bus_valid_q;
    // Uncached stores win the bus; weak ones may be passed
    assign drain_take = bus_free && drain_valid && state_q != S_BUS;

    ntf_wc_buffer #(
        .AW(AW),
        .IW(IW)
    ) u_wc (
        .clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .push_valid_in(state_q == S_WC),
        .push_addr_in(h_addr_q),
        .push_data_in(h_data_q),
        .push_be_in(h_be_q),
        .push_ready_out(wc_ready),
        .flush_in(wc_flush),
        .drain_valid_out(drain_valid),
        .drain_addr_out(drain_addr),
        .drain_data_out(drain_data),
        .drain_be_out(drain_be),
        .drain_take_in(drain_take),
        .empty_out(wc_empty)
    );

    // Request sequencing and pulse outputs
    always @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_q <= S_IDLE;
            ready_q <= 1'b1;
            h_addr_q <= {AW{1'b0}};
            h_data_q <= 64'h0;
            h_be_q <= 8'h00;
            h_mt_q <= `NTF_MT_UC;
            cwr_valid_q <= 1'b0;
            cwr_addr_q <= {AW{1'b0}};
            cwr_data_q <= 64'h0;
            cwr_be_q <= 8'h00;
            fill_valid_q <= 1'b0;
            fill_addr_q <= {AW{1'b0}};
            pf_valid_q <= 1'b0;
            pf_addr_q <= {AW{1'b0}};
            pf_level_q <= 2'h0;
            pf_nt_q <= 1'b0;
            fault_q <= 1'b0;
            fault_seen_q <= 1'b0;
            fault_addr_q <= {AW{1'b0}};
            nt_cnt_q <= 16'h0000;
            fence_cnt_q <= 16'h0000;
        end else begin
            cwr_valid_q <= 1'b0;
            fill_valid_q <= 1'b0;
            pf_valid_q <= 1'b0;
            fault_q <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (take) begin
                        h_addr_q <= eff_addr;
                        h_data_q <= req_data_in;
                        h_be_q <= eff_be;
                        h_mt_q <= req_memtype_in;
                        if (is_nt) begin
                            nt_cnt_q <= nt_cnt_q + 1'b1;
                        end
                        if (req_op_in == `NTF_OP_FENCE) begin
                            state_q <= S_FENCE;
                            ready_q <= 1'b0;
                        end else if (req_op_in == `NTF_OP_PREFETCH) begin
                            // Hint only: dropped when disabled, never faults
                            pf_valid_q <= ctrl_q[`NTF_CTRL_PF_EN];
                            pf_addr_q <= {req_addr_in[AW-1:`NTF_PF_LSB],
                                {`NTF_PF_LSB{1'b0}}};
                            pf_level_q <= req_hint_in;
                            pf_nt_q <= req_hint_in == `NTF_HINT_NT;
                        end else if (req_op_in == `NTF_OP_NT_PF &&
                                req_addr_in[`NTF_NTPF_ALIGN-1:0] != 0) begin
                            fault_q <= 1'b1;
                            fault_seen_q <= 1'b1;
                            fault_addr_q <= req_addr_in;
                        end else if (uncached) begin
                            state_q <= S_BUS;
                            ready_q <= 1'b0;
                        end else if (req_line_hit_in) begin
                            cwr_valid_q <= 1'b1;
                            cwr_addr_q <= eff_addr;
                            cwr_data_q <= req_data_in;
                            cwr_be_q <= eff_be;
                        end else if (is_nt ||
                                req_memtype_in == `NTF_MT_WC) begin
                            // No fill: the miss goes straight to combining
                            state_q <= S_WC;
                            ready_q <= 1'b0;
                        end else if (req_memtype_in == `NTF_MT_WB) begin
                            // Only ordinary write-back misses allocate
                            fill_valid_q <= 1'b1;
                            fill_addr_q <= {eff_addr[AW-1:IW+3],
                                {(IW+3){1'b0}}};
                            cwr_valid_q <= 1'b1;
                            cwr_addr_q <= eff_addr;
                            cwr_data_q <= req_data_in;
                            cwr_be_q <= eff_be;
                        end else begin
                            state_q <= S_BUS;
                            ready_q <= 1'b0;
                        end
                    end
                end
                S_BUS: begin
                    if (bus_free) begin
                        state_q <= S_IDLE;
                        ready_q <= 1'b1;
                    end
                end
                S_WC: begin
                    if (wc_ready) begin
                        state_q <= S_IDLE;
                        ready_q <= 1'b1;
                    end
                end
                S_FENCE: begin
                    // Later stores wait for every earlier write
                    if (wc_empty && bus_free) begin
                        state_q <= S_IDLE;
                        ready_q <= 1'b1;
                        fence_cnt_q <= fence_cnt_q + 1'b1;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                    ready_q <= 1'b1;
                end
            endcase
        end
    end

    // Memory bus write stage; a write is globally visible once taken
    always @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bus_valid_q <= 1'b0;
            bus_addr_q <= {AW{1'b0}};
            bus_data_q <= 64'h0;
            bus_be_q <= 8'h00;
            bus_mt_q <= `NTF_MT_UC;
            bus_weak_q <= 1'b0;
        end else if (bus_valid_q) begin
            if (bus_ready_in) begin
                bus_valid_q <= 1'b0;
            end
        end else if (state_q == S_BUS) begin
            bus_valid_q <= 1'b1;
            bus_addr_q <= h_addr_q;
            bus_data_q <= h_data_q;
            bus_be_q <= h_be_q;
            bus_mt_q <= h_mt_q;
            bus_weak_q <= 1'b0;
        end else if (drain_valid) begin
            bus_valid_q <= 1'b1;
            bus_addr_q <= drain_addr;
            bus_data_q <= drain_data;
            bus_be_q <= drain_be;
            bus_mt_q <= `NTF_MT_WC;
            bus_weak_q <= 1'b1;
        end
    end

    assign reg_wr = aw_have_q && w_have_q && !bvalid_q;

    // Register bus write channels, any order
    always @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= `NTF_RESP_OKAY;
            ctrl_q <= `NTF_CTRL_RESET;
            flush_req_q <= 1'b0;
        end else begin
            flush_req_q <= 1'b0;
            if (s_axi_awvalid_in && awready_q) begin
                aw_have_q <= 1'b1;
                awready_q <= 1'b0;
                awaddr_q <= s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in && wready_q) begin
                w_have_q <= 1'b1;
                wready_q <= 1'b0;
                wdata_q <= s_axi_wdata_in;
                wstrb_q <= s_axi_wstrb_in;
            end
            if (reg_wr) begin
                bvalid_q <= 1'b1;
                bresp_q <= `NTF_RESP_OKAY;
                case (reg_sel(awaddr_q))
                    3'h0: begin
                        if (wstrb_q[0]) begin
                            ctrl_q <= wdata_q[1:0];
                            flush_req_q <= wdata_q[`NTF_CTRL_FLUSH];
                        end
                    end
                    3'h1, 3'h2, 3'h3, 3'h4: begin
                        bresp_q <= `NTF_RESP_OKAY;
                    end
                    default: begin
                        bresp_q <= `NTF_RESP_SLVERR;
                    end
                endcase
            end
            if (bvalid_q && s_axi_bready_in) begin
                bvalid_q <= 1'b0;
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    // Register bus read channel
    always @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= `NTF_RESP_OKAY;
        end else if (rvalid_q) begin
            if (s_axi_rready_in) begin
                rvalid_q <= 1'b0;
                arready_q <= 1'b1;
            end
        end else if (s_axi_arvalid_in && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= `NTF_RESP_OKAY;
            rdata_q <= 32'h00000000;
            case (reg_sel(s_axi_araddr_in))
                3'h0: rdata_q[1:0] <= ctrl_q;
                3'h1: begin
                    rdata_q[`NTF_STAT_WC_EMPTY] <= wc_empty;
                    rdata_q[`NTF_STAT_FENCE] <= state_q == S_FENCE;
                    rdata_q[`NTF_STAT_FAULT] <= fault_seen_q;
                end
                3'h2: rdata_q <= fault_addr_q[31:0];
                3'h3: rdata_q[15:0] <= nt_cnt_q;
                3'h4: rdata_q[15:0] <= fence_cnt_q;
                default: rresp_q <= `NTF_RESP_SLVERR;
            endcase
        end
    end

    assign req_ready_out = ready_q;
    assign cwr_valid_out = cwr_valid_q;
    assign cwr_addr_out = cwr_addr_q;
    assign cwr_data_out = cwr_data_q;
    assign cwr_be_out = cwr_be_q;
    assign fill_valid_out = fill_valid_q;
    assign fill_addr_out = fill_addr_q;
    assign pf_valid_out = pf_valid_q;
    assign pf_addr_out = pf_addr_q;
    assign pf_level_out = pf_level_q;
    assign pf_nt_out = pf_nt_q;
    assign bus_valid_out = bus_valid_q;
    assign bus_addr_out = bus_addr_q;
    assign bus_data_out = bus_data_q;
    assign bus_be_out = bus_be_q;
    assign bus_memtype_out = bus_mt_q;
    assign bus_weak_out = bus_weak_q;
    assign fault_out = fault_q;
    assign fault_addr_out = fault_addr_q;
    assign s_axi_awready_out = awready_q;
    assign s_axi_wready_out = wready_q;
    assign s_axi_bresp_out = bresp_q;
    assign s_axi_bvalid_out = bvalid_q;
    assign s_axi_arready_out = arready_q;
    assign s_axi_rdata_out = rdata_q;
    assign s_axi_rresp_out = rresp_q;
    assign s_axi_rvalid_out = rvalid_q;
endmodule

/* verilog/ntf_wc_buffer.v */
// One-line write-combining buffer that merges weakly ordered stores
`timescale 1ns/100ps
module ntf_wc_buffer #(
    parameter AW = 32,
    parameter IW = 2
) (
    input wire clk_in,
    input wire rstn_in,
    input wire push_valid_in,
    input wire [AW-1:0] push_addr_in,
    input wire [63:0] push_data_in,
    input wire [7:0] push_be_in,
    output wire push_ready_out,
    input wire flush_in,
    output wire drain_valid_out,
    output wire [AW-1:0] drain_addr_out,
    output wire [63:0] drain_data_out,
    output wire [7:0] drain_be_out,
    input wire drain_take_in,
    output wire empty_out
);
    localparam WORDS = 1 << IW;
    localparam TW = AW - IW - 3;

    reg [63:0] data_q [0:WORDS-1];
    reg [7:0] be_q [0:WORDS-1];
    reg [TW-1:0] tag_q;
    reg [IW-1:0] ptr_q;
    reg valid_q;
    reg drain_q;
    wire [TW-1:0] push_tag;
    wire [IW-1:0] push_idx;
    wire step;
    integer i;
    integer b;

    assign push_tag = push_addr_in[AW-1:IW+3];
    assign push_idx = push_addr_in[IW+2:3];
    // Another line waits for a drain
    assign push_ready_out = !drain_q && (!valid_q || tag_q == push_tag);
    assign drain_valid_out = drain_q && (be_q[ptr_q] != 8'h00);
    assign drain_addr_out = {tag_q, ptr_q, 3'h0};
    assign drain_data_out = data_q[ptr_q];
    assign drain_be_out = be_q[ptr_q];
    assign empty_out = !valid_q;
    // Unwritten words are skipped, never sent empty
    assign step = drain_q && (drain_take_in || be_q[ptr_q] == 8'h00);

    // Merge, collapse and drain of the buffered line
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            for (i = 0; i < WORDS; i = i + 1) begin
                data_q[i] <= 64'h0;
                be_q[i] <= 8'h00;
            end
            tag_q <= {TW{1'b0}};
            ptr_q <= {IW{1'b0}};
            valid_q <= 1'b0;
            drain_q <= 1'b0;
        end else begin
            if (push_valid_in && push_ready_out) begin
                valid_q <= 1'b1;
                tag_q <= push_tag;
                for (b = 0; b < 8; b = b + 1) begin
                    if (push_be_in[b]) begin
                        data_q[push_idx][b*8 +: 8] <= push_data_in[b*8 +: 8];
                    end
                end
                be_q[push_idx] <= be_q[push_idx] | push_be_in;
            end
            if (flush_in && valid_q && !drain_q) begin
                drain_q <= 1'b1;
                ptr_q <= {IW{1'b0}};
            end
            if (step) begin
                be_q[ptr_q] <= 8'h00;
                ptr_q <= ptr_q + 1'b1;
                if (ptr_q == WORDS - 1) begin
                    drain_q <= 1'b0;
                    valid_q <= 1'b0;
                end
            end
        end
    end
endmodule
